// ===== clpu_core.sv
// cold load pickup detector: cold detect, load-off delay, inrush and max-block release
// assumes breaker and block pins are asynchronous; currents come from logic on clk_i
`timescale 1ns/100ps
module cold_load_pickup_detector
  import clpu_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES  // clock cycles per time-base tick
) (
  input  wire logic             clk_i,                 // system clock, 10 MHz
  input  wire logic             rst_b_i,               // async reset, active low
  input  wire logic             ce_i,                  // clock enable, freezes state
  input  wire logic             breaker_open_i,        // breaker open pin
  input  wire logic             ext_block_i,           // external block pin
  input  wire logic             int_block_i,           // internal block signal
  input  wire logic             ext_block_sel_i,       // use external block
  input  wire logic             int_block_sel_i,       // use internal block
  input  wire logic             auto_reclose_running_i,// auto-reclose sequence active
  input  wire logic [1:0]       detect_mode_i,         // detection method
  input  wire logic [CUR_W-1:0] current_i,             // max phase current
  input  wire logic [CUR_W-1:0] undercur_thr_i,        // undercurrent threshold
  input  wire logic [CUR_W-1:0] inrush_thr_i,          // inrush threshold
  input  wire logic [TIMER_W-1:0] t_load_off_i,        // load-off delay, ticks
  input  wire logic [TIMER_W-1:0] t_settle_i,          // settle time, ticks
  input  wire logic [TIMER_W-1:0] t_max_block_i,       // max-block time, ticks
  output logic                  cold_load_enable_out_o,// enable status
  output logic                  no_current_indication_o,// undercurrent status
  output logic                  inrush_o               // inrush present status
);
  typedef enum logic [2:0] {S_WARM, S_LOAD_OFF, S_COLD, S_INRUSH, S_SETTLE} state_e;

  state_e state_q;
  logic [2:0] brk_sync_q, ext_sync_q;
  logic       brk_q, ext_q;
  logic [15:0] pre_q;
  logic       tick;
  logic       undercur, cold, blocked, inrush_hi, inrush_low;
  logic       lo_start, settle_start, mb_start, mb_run;
  logic       lo_done, settle_done, mb_done;
  logic       en_q, uc_q, inr_q;
  logic [CUR_W+3:0] cur10, thr9;

  // three-stage synchronisers, change taken when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brk_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
      brk_q      <= 1'b0;
      ext_q      <= 1'b0;
    end else if (ce_i) begin
      brk_sync_q <= {brk_sync_q[1:0], breaker_open_i};
      ext_sync_q <= {ext_sync_q[1:0], ext_block_i};
      if (brk_sync_q[1] == brk_sync_q[2]) brk_q <= brk_sync_q[2];
      if (ext_sync_q[1] == ext_sync_q[2]) ext_q <= ext_sync_q[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= 16'h0;
    end else if (ce_i) begin
      pre_q <= (pre_q == 16'(TICK_CYC - 1)) ? 16'h0 : pre_q + 16'h1;
    end
  end
  assign tick = ce_i && (pre_q == 16'(TICK_CYC - 1));

  // inrush thresholds, drop-off at nine tenths
  assign cur10      = (CUR_W+4)'(current_i) * (CUR_W+4)'(DROP_DEN);
  assign thr9       = (CUR_W+4)'(inrush_thr_i) * (CUR_W+4)'(DROP_NUM);
  assign inrush_hi  = current_i > inrush_thr_i;
  assign inrush_low = cur10 <= thr9;
  assign undercur   = current_i < undercur_thr_i;

  always_comb begin
    case (detect_mode_e'(detect_mode_i))
      breaker_position_method:    cold = brk_q;
      undercurrent_method:        cold = undercur;
      breaker_and_current_method: cold = brk_q && undercur;
      breaker_or_current_method:  cold = brk_q || undercur;
      default:                    cold = 1'b0;
    endcase
  end

  assign blocked = (ext_block_sel_i && ext_q) || (int_block_sel_i && int_block_i)
                 || auto_reclose_running_i;

  // main sequence
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= S_WARM;
    end else if (ce_i) begin
      if (blocked) begin
        state_q <= S_WARM;
      end else begin
        case (state_q)
          S_WARM:     if (cold) state_q <= S_LOAD_OFF;
          S_LOAD_OFF: if (!cold) state_q <= S_WARM;
                      else if (lo_done) state_q <= S_COLD;
          S_COLD:     if (!cold) state_q <= S_INRUSH;
          S_INRUSH: begin
            if (mb_done) state_q <= S_WARM;
            else if (cold) state_q <= S_LOAD_OFF;
            else if (inrush_low) state_q <= S_SETTLE;
          end
          S_SETTLE: begin
            if (mb_done || settle_done) state_q <= S_WARM;
            else if (cold) state_q <= S_LOAD_OFF;
            else if (!inrush_low) state_q <= S_INRUSH;
          end
          default:    state_q <= S_WARM;
        endcase
      end
    end
  end

  assign lo_start     = (state_q == S_WARM) && cold && !blocked;
  assign settle_start = (state_q == S_INRUSH) && inrush_low;
  assign mb_start     = (state_q == S_COLD) && !cold;
  assign mb_run       = (state_q == S_INRUSH) || (state_q == S_SETTLE);

  clpu_timer #(.W(TIMER_W)) u_load_off (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .start_i (lo_start),
    .run_i   (state_q == S_LOAD_OFF),
    .tick_i  (tick),
    .limit_i (t_load_off_i),
    .done_o  (lo_done)
  );

  clpu_timer #(.W(TIMER_W)) u_settle (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .start_i (settle_start),
    .run_i   (state_q == S_SETTLE),
    .tick_i  (tick),
    .limit_i (t_settle_i),
    .done_o  (settle_done)
  );

  clpu_timer #(.W(TIMER_W)) u_max_block (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .start_i (mb_start),
    .run_i   (mb_run),
    .tick_i  (tick),
    .limit_i (t_max_block_i),
    .done_o  (mb_done)
  );

  // registered status outputs only, no trip
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_q  <= 1'b0;
      uc_q  <= 1'b0;
      inr_q <= 1'b0;
    end else if (ce_i) begin
      en_q  <= (state_q == S_COLD) || (state_q == S_INRUSH) || (state_q == S_SETTLE);
      uc_q  <= undercur;
      // inrush held until current drops to nine tenths
      inr_q <= (state_q == S_INRUSH) && (inrush_hi || (inr_q && !inrush_low));
    end
  end
  assign cold_load_enable_out_o  = en_q;
  assign no_current_indication_o = uc_q;
  assign inrush_o                = inr_q;

  // helper for the bound on enable duration
  logic [TIMER_W:0] en_ticks_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) en_ticks_q <= '0;
    else if (ce_i) begin
      if (!mb_run) en_ticks_q <= '0;
      else if (tick) en_ticks_q <= en_ticks_q + 1'b1;
    end
  end

  a_maxblock_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    en_ticks_q <= {1'b0, t_max_block_i} + 1'b1)
    else $error("enable outlived max-block time");
  a_block_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && blocked |=> state_q == S_WARM)
    else $error("block did not idle the function");
  a_load_off_en: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && state_q == S_LOAD_OFF && lo_done && cold && !blocked
    |=> state_q == S_COLD)
    else $error("load-off expiry did not enable");
  a_inrush_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && mb_start && !blocked |=> state_q == S_INRUSH)
    else $error("inrush watch not started");
  a_settle_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && state_q == S_SETTLE && settle_done |=> ##1 !cold_load_enable_out_o)
    else $error("enable held past settle");
  a_inrush_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && state_q == S_INRUSH && inrush_hi |=> inrush_o)
    else $error("inrush not flagged above threshold");
  // inrush flag holds above the drop-off level
  a_inrush_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && state_q == S_INRUSH && inrush_o && !inrush_low |=> inrush_o)
    else $error("inrush flag dropped above drop-off level");
endmodule // cold_load_pickup_detector

// ===== clpu_pkg.sv
// package for the cold load pickup detector: modes, timing constants
// assumes a 10 MHz system clock and a 1 ms time base for all timers
// How it works
// - cold state is found from breaker open, no current, both together, or either one.
// - entering the cold state starts the load-off delay.
// - when the load-off delay runs out the enable output rises.
// - when the cold state ends the inrush watch begins.
// - current above the inrush threshold means inrush is present.
// - inrush is over once current is at or below nine tenths of the threshold.
// - the end of inrush starts the settle timer.
// - the inrush path drops the enable only after the settle timer runs out.
// - the end of the cold state also starts the max-block timer, whose expiry drops the enable.
// - the max-block timer stops once current stays at or below nine tenths for the settle time.
// - from the end of the cold state the enable lasts no longer than the max-block time.
// - a selected block input holds the sequence and the enable idle; the undercurrent status still follows the current.
// - a running auto-reclose sequence blocks the function.
// - the block only gives a status output and never a trip.
package clpu_pkg;
  // detection methods
  typedef enum logic [1:0] {
    breaker_position_method,
    undercurrent_method,
    breaker_and_current_method,
    breaker_or_current_method
  } detect_mode_e;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_TIME_US  = 1000;  // time base period, microseconds
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_TIME_US;
  localparam int unsigned TIMER_W       = 16;    // timer width in bits, counts ticks
  localparam int unsigned CUR_W         = 16;    // current magnitude width
  localparam int unsigned DROP_NUM      = 9;     // drop-off ratio numerator
  localparam int unsigned DROP_DEN      = 10;    // drop-off ratio denominator
endpackage

// ===== clpu_timer.sv
// delay timer counting time-base ticks
// assumes tick_i is a one-cycle pulse on clk_i
`timescale 1ns/100ps
module clpu_timer
  import clpu_pkg::*;
#(
  parameter int unsigned W = TIMER_W
) (
  input  wire logic         clk_i,    // system clock
  input  wire logic         rst_b_i,  // async reset, active low
  input  wire logic         ce_i,     // clock enable
  input  wire logic         start_i,  // restart from zero
  input  wire logic         run_i,    // count while high
  input  wire logic         tick_i,   // time base pulse
  input  wire logic [W-1:0] limit_i,  // delay in ticks
  output logic              done_o    // delay elapsed, level
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (start_i || !run_i) begin
        cnt_q <= '0;
      end else if (tick_i && cnt_q != limit_i) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign done_o = run_i && !start_i && (cnt_q == limit_i);
endmodule // clpu_timer

// ===== clpu_field_model.sv
// field model: breaker position contacts and phase current measurement
// assumes the bench changes its commands just after rising edges of clk_i
`timescale 1ns/100ps
module clpu_field_model
  import clpu_pkg::*;
(
  input  wire logic             clk_i,          // system clock
  input  wire logic             open_cmd_i,     // wanted breaker position
  input  wire logic [CUR_W-1:0] amps_cmd_i,     // wanted load current
  output logic                  breaker_open_o, // open contact, high when open
  output logic      [CUR_W-1:0] current_o       // measured current magnitude
);
  // contacts and measurement follow the commands one cycle late
  always_ff @(posedge clk_i) begin
    breaker_open_o <= open_cmd_i;
    current_o      <= amps_cmd_i;
  end
endmodule // clpu_field_model

// ===== cold_load_pickup_detector_tb.sv
// self-checking bench for the cold load pickup detector
// assumes one 10 MHz clock; breaker and current come from the field model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module cold_load_pickup_detector_tb;
  import clpu_pkg::*;
  logic               clk_i = 0, rst_b_i = 0, brk_cmd = 0, ar = 0;
  // time base shortened to ten cycles a tick to keep the run short
  localparam int unsigned TCK = 10;
  logic               ext_blk = 0, int_blk = 0, esel = 1, isel = 1, ce = 1;
  logic [1:0]         mode = 2'h0;
  logic [CUR_W-1:0]   amps = 16'h0000, cur;
  logic [TIMER_W-1:0] tlo = 16'h0002, tst = 16'h0001, tmb = 16'h0005;
  logic               brk_open, en, noc, inr;
  int                 err_total = 0, cmp_count = 0, n;

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  clpu_field_model clpu_field_model_inst (
    .clk_i(clk_i), .open_cmd_i(brk_cmd), .amps_cmd_i(amps),
    .breaker_open_o(brk_open), .current_o(cur));

  cold_load_pickup_detector #(.TICK_CYC(TCK)) cold_load_pickup_detector_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .breaker_open_i(brk_open),
    .ext_block_i(ext_blk), .int_block_i(int_blk), .ext_block_sel_i(esel),
    .int_block_sel_i(isel), .auto_reclose_running_i(ar), .detect_mode_i(mode),
    .current_i(cur), .undercur_thr_i(16'h0064), .inrush_thr_i(16'h03e8),
    .t_load_off_i(tlo), .t_settle_i(tst), .t_max_block_i(tmb),
    .cold_load_enable_out_o(en), .no_current_indication_o(noc), .inrush_o(inr));

  // wait cycles, ending on a falling edge where outputs are settled
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  // set breaker position and load current just after a rising edge
  task automatic setf(input logic b, input logic [CUR_W-1:0] a);
    @(posedge clk_i);
    brk_cmd <= b;
    amps    <= a;
  endtask

  // wait for the enable to reach a level, counting cycles
  task automatic wait_en(input logic v, input int lim, output int k);
    k = 0;
    while (en !== v && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    `CHK("enable", v, en)
  endtask

  // verdict and end of run
  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cyc(1);
    `CHK("enable_rst", 1'b0, en)
    // breaker opens, two-tick load-off delay
    setf(1'b1, 16'h0000);
    wait_en(1'b1, 3 * TCK + 10, n);
    `CHK("load_off_min", 1'b1, n >= 2 * TCK)
    `CHK("undercur", 1'b1, noc)
    // breaker closes with no inrush: settle path releases
    setf(1'b0, 16'h0000);
    wait_en(1'b0, 3 * TCK, n);
    `CHK("no_inrush", 1'b0, inr)
    // prolonged inrush: max-block releases, drop-off at nine tenths
    @(posedge clk_i);
    tlo <= 16'h0000;
    tst <= 16'h0005;
    tmb <= 16'h0008;
    setf(1'b1, 16'h0000);
    wait_en(1'b1, 100, n);
    setf(1'b0, 16'h05dc);
    cyc(8);
    `CHK("inrush_on", 1'b1, inr)
    setf(1'b0, 16'h0385);
    cyc(8);
    `CHK("inrush_901", 1'b1, inr)
    setf(1'b0, 16'h0384);
    cyc(8);
    `CHK("inrush_900", 1'b0, inr)
    setf(1'b0, 16'h05dc);
    cyc(8);
    `CHK("inrush_back", 1'b1, inr)
    // max-block began 26 cycles before this wait and runs 7 to 8 ticks
    wait_en(1'b0, 8 * TCK - 20, n);
    `CHK("max_block_min", 1'b1, n >= 7 * TCK - 26)
    // every detection method against closed-idle and open-loaded feeder
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      ext_blk <= 1'b1;
      cyc(8);
      @(posedge clk_i);
      mode    <= m[1:0];
      brk_cmd <= m[2];
      amps    <= m[2] ? 16'h07d0 : 16'h0000;
      ext_blk <= 1'b0;
      cyc(40);
      `CHK("mode_en", 8'h9a >> m & 1'b1, {7'h00, en})
      `CHK("undercur_m", !m[2], noc)
    end
    // block sources: unselected external, external, internal, auto-reclose
    for (int b = 0; b < 4; b++) begin
      @(posedge clk_i);
      esel    <= (b != 0);
      isel    <= (b != 0);
      ext_blk <= 1'b0;
      int_blk <= 1'b0;
      ar      <= 1'b0;
      cyc(40);
      `CHK("pre_blk", 1'b1, en)
      @(posedge clk_i);
      ext_blk <= (b < 2);
      int_blk <= (b == 0) || (b == 2);
      ar      <= (b == 3);
      cyc(10);
      `CHK("blocked", b == 0, en)
    end
    // auto-reclose ends, then clock enable low freezes the block
    @(posedge clk_i);
    ar <= 1'b0;
    cyc(10);
    `CHK("ar_release", 1'b1, en)
    @(posedge clk_i);
    ce <= 1'b0;
    ar <= 1'b1;
    cyc(10);
    `CHK("ce_frozen", 1'b1, en)
    @(posedge clk_i);
    ce <= 1'b1;
    cyc(4);
    `CHK("ce_resume", 1'b0, en)
    finish_test;
  end

  // watchdog against a hung wait
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    finish_test;
  end
endmodule // cold_load_pickup_detector_tb
